/* emb_regs.vh */
// shared constants for the external memory bus pin block
// assumes a 10 MHz core clock and four clocks per machine cycle
`ifndef EMB_REGS_VH
`define EMB_REGS_VH
`define EMB_CLK_NS 100
`define EMB_CLKS_PER_MC 4
`define EMB_MC_W 2
`define EMB_MC_LAST 2'h3
`define EMB_RST_MC 2
`define EMB_RST_CLKS (`EMB_RST_MC * `EMB_CLKS_PER_MC)
`define EMB_RST_CNT_W 4
`define EMB_STRETCH_W 3
`define EMB_STRETCH_MIN 3'h0
`define EMB_STRETCH_MAX 3'h7
`define EMB_WR_BIT 6
`define EMB_RD_BIT 7
`define EMB_WAIT_BIT 0
`define EMB_REBOOT_BIT 3
`define EMB_ST_IDLE 3'h0
`define EMB_ST_ADDR 3'h1
`define EMB_ST_HOLD 3'h2
`define EMB_ST_DATA 3'h3
`define EMB_ST_WAIT 3'h4
`define EMB_ST_END 3'h5
`define EMB_KIND_CODE 2'h0
`define EMB_KIND_TBL 2'h1
`define EMB_KIND_RD 2'h2
`define EMB_KIND_WR 2'h3
`endif

/* emb_sync.v */
// two flip-flop synchroniser for one asynchronous pin
// assumes the pin level is unrelated to the core clock
`timescale 1ns/1ps
module emb_sync (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_async,
	output reg o_sync
);
	reg meta;
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule // emb_sync

/* emb_reset.v */
// reset pin filter: full reset only after a long enough high level
// assumes the reset pin is already synchronised to the core clock
`timescale 1ns/1ps
`include "emb_regs.vh"
module emb_reset (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_pin_high,
	output reg o_reset
);
	reg [`EMB_RST_CNT_W-1:0] cnt;
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt <= {`EMB_RST_CNT_W{1'b0}};
			o_reset <= 1'b0;
		end else if (!i_pin_high) begin
			cnt <= {`EMB_RST_CNT_W{1'b0}};
			o_reset <= 1'b0;
		end else if (cnt < `EMB_RST_CLKS) begin
			cnt <= cnt + 4'h1;
			o_reset <= 1'b0;
		end else begin
			// a short glitch never reaches the core
			o_reset <= 1'b1;
		end
	end
endmodule // emb_reset

/* emb_bus.v */
// external memory bus sequencer: drives the pins of ports 0,2,3,4
// assumes the core raises one request at a time and holds it until done
`timescale 1ns/1ps
`include "emb_regs.vh"
module emb_bus (
	input wire I_CORE_CLK,
	input wire I_RST_N,
	input wire i_req,
	input wire [1:0] i_kind,
	input wire [15:0] i_addr,
	input wire [7:0] i_wdata,
	input wire [2:0] i_stretch,
	input wire i_wait_en,
	input wire i_p0_pullup_en,
	input wire [7:0] i_p0_port,
	input wire [7:0] i_p2_port,
	input wire [7:0] i_p3_port,
	input wire [3:0] i_p4_port,
	input wire i_external_access_select_n,
	input wire i_reset_pin,
	input wire [7:0] i_p0,
	input wire [7:0] i_p2,
	input wire [7:0] i_p3,
	input wire [3:0] i_p4,
	output wire o_ack,
	output reg [7:0] o_rdata,
	output wire o_internal,
	output wire o_core_reset,
	output reg o_reboot,
	output reg o_machine_tick,
	output reg [7:0] o_p0,
	output reg [7:0] o_p0_oe,
	output reg o_p0_pullup,
	output reg [7:0] o_p2,
	output reg [7:0] o_p2_oe,
	output reg [7:0] o_p3,
	output reg [7:0] o_p3_oe,
	output reg [3:0] o_p4,
	output reg [3:0] o_p4_oe,
	output reg o_address_latch_strobe,
	output reg o_program_store_strobe_n
);
	reg [`EMB_MC_W-1:0] phase;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [2:0] mc_left;
	reg [1:0] kind;
	reg [15:0] addr;
	reg [7:0] wdata;
	reg ack;
	wire ea_sync;
	wire wait_sync;
	wire reboot_sync;
	wire rst_sync;
	wire [7:0] p0_sync;
	wire mc_end;
	wire is_code;
	wire go_ext;
	reg reboot_prev;
	wire kind_wr;
	wire kind_rd;
	wire data_move;
	wire wait_hold;
	wire [15:0] addr_now;

	// sequencer states, one per bus phase
	localparam [2:0] ST_IDLE = `EMB_ST_IDLE;
	localparam [2:0] ST_ADDR = `EMB_ST_ADDR;
	localparam [2:0] ST_HOLD = `EMB_ST_HOLD;
	localparam [2:0] ST_DATA = `EMB_ST_DATA;
	localparam [2:0] ST_WAIT = `EMB_ST_WAIT;
	localparam [2:0] ST_END = `EMB_ST_END;
	// access kinds as the core codes them
	localparam [1:0] KIND_CODE = `EMB_KIND_CODE;
	localparam [1:0] KIND_TBL = `EMB_KIND_TBL;
	localparam [1:0] KIND_RD = `EMB_KIND_RD;
	localparam [1:0] KIND_WR = `EMB_KIND_WR;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_p0
			emb_sync u_s (
				.i_clk(I_CORE_CLK),
				.i_rst_n(I_RST_N),
				.i_async(i_p0[g]),
				.o_sync(p0_sync[g])
			);
		end
	endgenerate
	emb_sync u_ea (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_async(i_external_access_select_n),
		.o_sync(ea_sync)
	);
	emb_sync u_wait (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_async(i_p4[`EMB_WAIT_BIT]),
		.o_sync(wait_sync)
	);
	emb_sync u_reboot (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_async(i_p4[`EMB_REBOOT_BIT]),
		.o_sync(reboot_sync)
	);
	emb_sync u_rpin (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_async(i_reset_pin),
		.o_sync(rst_sync)
	);
	emb_reset u_rst (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_pin_high(rst_sync),
		.o_reset(o_core_reset)
	);

	// machine cycle base: the address phase lasts a whole machine cycle, the hold and end phases one clock each
	always @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			phase <= {`EMB_MC_W{1'b0}};
			o_machine_tick <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			o_machine_tick <= (phase == `EMB_MC_LAST);
		end
	end
	assign mc_end = (phase == `EMB_MC_LAST);

	// reboot pin is an edge request to the core
	always @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			reboot_prev <= 1'b0;
			o_reboot <= 1'b0;
		end else begin
			reboot_prev <= reboot_sync;
			o_reboot <= reboot_sync & ~reboot_prev;
		end
	end

	assign is_code = (i_kind == KIND_CODE) || (i_kind == KIND_TBL);
	assign data_move = (i_kind == KIND_RD) || (i_kind == KIND_WR);
	assign kind_wr = (kind == KIND_WR);
	assign kind_rd = (kind == KIND_RD);
	// wait pin is active low and only counts while its function is on
	assign wait_hold = i_wait_en && !wait_sync;
	// first bus edge takes the address straight from the request
	assign addr_now = (state == ST_IDLE) ? i_addr : addr;
	// code with select high never leaves the chip
	assign o_internal = ea_sync;
	assign go_ext = i_req && !(is_code && ea_sync);
	assign o_ack = ack;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (go_ext && mc_end && !ack)
					next_state = ST_ADDR;
			end
			ST_ADDR: begin
				if (mc_end)
					next_state = ST_HOLD;
			end
			ST_HOLD: begin
				next_state = ST_DATA;
			end
			ST_DATA: begin
				if (mc_end && mc_left == 3'h0)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				// sampled late so the strobe is already seen outside
				if (!wait_hold)
					next_state = ST_END;
			end
			ST_END: begin
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge I_CORE_CLK) begin
		if (!I_RST_N || o_core_reset) begin
			state <= ST_IDLE;
			mc_left <= 3'h0;
			kind <= KIND_CODE;
			addr <= 16'h0000;
			wdata <= 8'h00;
			ack <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			state <= next_state;
			ack <= 1'b0;
			if (state == ST_IDLE && next_state == ST_ADDR) begin
				kind <= i_kind;
				addr <= i_addr;
				wdata <= i_wdata;
				// data moves take 2 + stretch machine cycles
				if (data_move)
					mc_left <= i_stretch;
				else
					mc_left <= 3'h0;
			end
			if (state == ST_DATA && mc_end && mc_left != 3'h0)
				mc_left <= mc_left - 3'h1;
			if (state == ST_IDLE && i_req && !go_ext && mc_end &&
				!ack)
				ack <= 1'b1;
			if (state == ST_WAIT && next_state == ST_END) begin
				if (!kind_wr)
					o_rdata <= p0_sync;
			end
			if (state == ST_END)
				ack <= 1'b1;
		end
	end

	// pin drive, registered so the pads never see decode glitches
	always @(posedge I_CORE_CLK) begin
		if (!I_RST_N || o_core_reset) begin
			o_p0 <= 8'hff;
			o_p0_oe <= 8'h00;
			o_p0_pullup <= 1'b0;
			o_p2 <= 8'hff;
			o_p2_oe <= 8'h00;
			o_p3 <= 8'hff;
			o_p3_oe <= 8'h00;
			o_p4 <= 4'hf;
			o_p4_oe <= 4'h0;
			o_address_latch_strobe <= 1'b0;
			o_program_store_strobe_n <= 1'b1;
		end else begin
			o_address_latch_strobe <= (next_state == ST_ADDR);
			o_program_store_strobe_n <= 1'b1;
			o_p0_pullup <= i_p0_pullup_en;
			// pulled-up ports: drive only a low, the pull-up gives high
			o_p2 <= i_p2_port;
			o_p2_oe <= ~i_p2_port;
			o_p3 <= i_p3_port;
			o_p3_oe <= ~i_p3_port;
			o_p4 <= i_p4_port;
			o_p4_oe <= ~i_p4_port;
			if (i_wait_en)
				o_p4_oe[`EMB_WAIT_BIT] <= 1'b0;
			// open-drain port zero outside bus cycles
			o_p0 <= i_p0_port;
			o_p0_oe <= ~i_p0_port;
			case (next_state)
				ST_ADDR, ST_HOLD: begin
					// address stays through the strobe fall
					o_p0 <= addr_now[7:0];
					o_p0_oe <= 8'hff;
				end
				ST_DATA, ST_WAIT, ST_END: begin
					o_p0 <= wdata;
					o_p0_oe <= kind_wr ? 8'hff : 8'h00;
					if (next_state != ST_END) begin
						if (kind_wr)
							o_p3[`EMB_WR_BIT] <= 1'b0;
						else if (kind_rd)
							o_p3[`EMB_RD_BIT] <= 1'b0;
						else
							o_program_store_strobe_n <= 1'b0;
						if (kind_wr)
							o_p3_oe[`EMB_WR_BIT] <= 1'b1;
						else if (kind_rd)
							o_p3_oe[`EMB_RD_BIT] <= 1'b1;
					end
				end
				default: begin
				end
			endcase
			if (next_state != ST_IDLE) begin
				o_p2 <= addr_now[15:8];
				o_p2_oe <= 8'hff;
			end
		end
	end
endmodule // emb_bus

/* emb_bus_chk.sv */
// assertions on the pins of the external memory bus block
// assumes the core holds one request until its acknowledge
`timescale 1ns/1ps
module emb_chk (
	input wire I_CORE_CLK,
	input wire I_RST_N,
	input wire i_req,
	input wire [1:0] i_kind,
	input wire [15:0] i_addr,
	input wire o_internal,
	input wire o_core_reset,
	input wire o_machine_tick,
	input wire [7:0] o_p0,
	input wire [7:0] o_p0_oe,
	input wire [7:0] o_p2,
	input wire [7:0] o_p2_oe,
	input wire [7:0] o_p3,
	input wire [7:0] o_p3_oe,
	input wire o_address_latch_strobe,
	input wire o_program_store_strobe_n
);
default clocking @(posedge I_CORE_CLK); endclocking
// the pin reset restarts the sequencer, so it masks checks too
default disable iff (!I_RST_N || o_core_reset);
property p_int_quiet;
	o_internal |-> o_program_store_strobe_n;
endproperty
a_int_quiet: assert property (p_int_quiet)
	else $error("store strobe on internal code");
property p_int_nobus;
	o_internal && i_req && !i_kind[1] |-> !o_address_latch_strobe;
endproperty
a_int_nobus: assert property (p_int_nobus) else $error("bus used for internal code");
property p_ale_addr;
	o_address_latch_strobe |-> o_p0 == i_addr[7:0] && o_p2 == i_addr[15:8] && o_p0_oe == 8'hff;
endproperty
a_ale_addr: assert property (p_ale_addr) else $error("address not on ports");
property p_ale_fall;
	$fell(o_address_latch_strobe) |-> $stable(o_p0) && o_p0_oe == 8'hff;
endproperty
a_ale_fall: assert property (p_ale_fall) else $error("address moved at latch fall");
property p_ale_pulse;
	$rose(o_address_latch_strobe) |-> ##[1:4] !o_address_latch_strobe;
endproperty
a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too long");
property p_rd;
	$fell(o_p3[7]) |-> i_req && i_kind == 2'h2;
endproperty
a_rd: assert property (p_rd) else $error("read strobe without data read");
property p_wr;
	$fell(o_p3[6]) |-> i_req && i_kind == 2'h3;
endproperty
a_wr: assert property (p_wr) else $error("write strobe without data write");
property p_tick;
	o_machine_tick |=> !o_machine_tick [*3] ##1 o_machine_tick;
endproperty
a_tick: assert property (p_tick) else $error("machine cycle not four clocks");
property p_program_store_strobe;
	$fell(o_program_store_strobe_n) |-> i_req && !i_kind[1];
endproperty
a_program_store_strobe: assert property (p_program_store_strobe)
	else $error("store strobe without code access");
property p_p2_drive;
	o_address_latch_strobe |-> o_p2_oe == 8'hff;
endproperty
a_p2_drive: assert property (p_p2_drive)
	else $error("upper address not driven");
property p_rd_drive;
	!o_p3[7] |-> o_p3_oe[7];
endproperty
a_rd_drive: assert property (p_rd_drive)
	else $error("read strobe low but not driven");
property p_wr_drive;
	!o_p3[6] |-> o_p3_oe[6];
endproperty
a_wr_drive: assert property (p_wr_drive)
	else $error("write strobe low but not driven");
endmodule // emb_chk
bind emb_bus emb_chk emb_chk_i (.I_CORE_CLK, .I_RST_N, .i_req, .i_kind,
	.i_addr, .o_internal, .o_core_reset, .o_machine_tick, .o_p0, .o_p0_oe,
	.o_p2, .o_p2_oe, .o_p3, .o_p3_oe,
	.o_address_latch_strobe, .o_program_store_strobe_n);

/* emb_mem.sv */
// external code and data memory with its address latch
// assumes the device's port zero outputs and strobes as inputs
`timescale 1ns/1ps
module emb_mem (
	input wire i_clk,
	input wire [7:0] i_ad,
	input wire [7:0] i_ad_oe,
	input wire i_ale,
	input wire i_code_n,
	input wire i_rd_n,
	input wire i_wr_n,
	input wire i_slow,
	output wire [7:0] o_ad,
	output wire o_wait_n
);
reg [7:0] mem [0:255];
reg [7:0] lat;
reg [7:0] last;
reg [3:0] hold = 4'h0;
reg sel = 1'b0;
integer k;
wire en = !i_code_n || !i_rd_n;
// an undriven bus shows the inverse of its last level, never a stale match
assign o_ad = (i_ad_oe & i_ad) | (~i_ad_oe & (en ? mem[lat] : ~last));
assign o_wait_n = hold == 4'h0;
initial for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'h5a;
always @(posedge i_clk) begin
	last <= o_ad;
	if (i_ale) lat <= i_ad;
	if (!i_wr_n) mem[lat] <= i_ad;
	sel <= en || !i_wr_n;
	if ((en || !i_wr_n) && !sel && i_slow) hold <= 4'h6;
	else if (hold != 4'h0) hold <= hold - 4'h1;
end
endmodule // emb_mem

/* testbench.sv */
// self-checking bench for the external memory bus block
// assumes emb_mem stands on port zero and the wait pin
`timescale 1ns/1ps
module testbench;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg req = 1'b0;
reg [1:0] kind = 2'h0;
reg [15:0] addr = 16'h0000;
reg [7:0] wdata = 8'h00;
reg [2:0] stretch = 3'h0;
reg wait_en = 1'b0, pu = 1'b0, ea_n = 1'b0, rpin = 1'b0, boot = 1'b0;
reg slow = 1'b0;
wire [7:0] p0, p0_oe, p2, p3, rdata, ad;
wire [3:0] p4, p4_oe;
wire ack, intl, core_rst, reboot, pull, ale, program_store_strobe_n, wait_n;
integer miscompares = 0, checks = 0, n, base;
always #50 clk = ~clk;
emb_bus emb_bus_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .i_req(req),
	.i_kind(kind), .i_addr(addr), .i_wdata(wdata), .i_stretch(stretch),
	.i_wait_en(wait_en), .i_p0_pullup_en(pu), .i_p0_port(8'hff),
	.i_p2_port(8'hff), .i_p3_port(8'hff), .i_p4_port(4'he),
	.i_external_access_select_n(ea_n), .i_reset_pin(rpin), .i_p0(ad),
	.i_p2(p2), .i_p3(p3), .i_p4({boot, p4[2:1], wait_n}), .o_ack(ack),
	.o_rdata(rdata), .o_internal(intl), .o_core_reset(core_rst),
	.o_reboot(reboot), .o_machine_tick(), .o_p0(p0), .o_p0_oe(p0_oe),
	.o_p0_pullup(pull), .o_p2(p2), .o_p2_oe(), .o_p3(p3), .o_p3_oe(),
	.o_p4(p4), .o_p4_oe(p4_oe), .o_address_latch_strobe(ale),
	.o_program_store_strobe_n(program_store_strobe_n));
emb_mem emb_mem_i (.i_clk(clk), .i_ad(p0), .i_ad_oe(p0_oe), .i_ale(ale),
	.i_code_n(program_store_strobe_n), .i_rd_n(p3[7]), .i_wr_n(p3[6]), .i_slow(slow),
	.o_ad(ad), .o_wait_n(wait_n));
task check(input logic [15:0] got, input logic [15:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end
endtask
task tick(input integer c);
	begin
		repeat (c) @(posedge clk);
		#1;
	end
endtask
task access(input [1:0] k, input [15:0] a, input [7:0] d);
	begin
		tick(1);
		req = 1'b1;
		kind = k;
		addr = a;
		wdata = d;
		n = 0;
		while (ack !== 1'b1 && n < 300) begin
			tick(1);
			n = n + 1;
		end
		req = 1'b0;
		check(n < 300, 1);
	end
endtask
task t_ext;
	begin
		access(2'h0, 16'h1234, 8'h00);
		check(rdata, 8'h6e);
		access(2'h1, 16'h12a5, 8'h00);
		check(rdata, 8'hff);
		access(2'h3, 16'h0040, 8'hc3);
		access(2'h2, 16'h0040, 8'h00);
		check(rdata, 8'hc3);
		access(2'h2, 16'h0040, 8'h00);
		base = n;
		stretch = 3'h7;
		access(2'h2, 16'h0040, 8'h00);
		check(n - base, 28);
		stretch = 3'h0;
		$display("external accesses done");
	end
endtask
task t_wait;
	begin
		slow = 1'b1;
		access(2'h2, 16'h0040, 8'h00);
		check(n, base);
		wait_en = 1'b1;
		tick(4);
		check(p4_oe[0], 0);
		access(2'h2, 16'h0040, 8'h00);
		check(n > base, 1);
		check(rdata, 8'hc3);
		wait_en = 1'b0;
		slow = 1'b0;
		$display("wait states done");
	end
endtask
task t_int;
	begin
		ea_n = 1'b1;
		tick(4);
		check(intl, 1);
		access(2'h0, 16'h0100, 8'h00);
		check(n < 8, 1);
		ea_n = 1'b0;
		tick(4);
		$display("internal code done");
	end
endtask
task t_pins;
	begin
		rpin = 1'b1;
		tick(4);
		rpin = 1'b0;
		tick(6);
		check(core_rst, 0);
		rpin = 1'b1;
		tick(12);
		check(core_rst, 1);
		rpin = 1'b0;
		tick(6);
		boot = 1'b1;
		n = 0;
		while (reboot !== 1'b1 && n < 8) begin
			tick(1);
			n = n + 1;
		end
		check(reboot, 1);
		boot = 1'b0;
		pu = 1'b1;
		tick(3);
		check(pull, 1);
		pu = 1'b0;
		tick(3);
		check(pull, 0);
		$display("reset, reboot and pull-up done");
	end
endtask
task finish_test;
	begin
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
endtask
initial begin
	tick(2);
	rst_n = 1'b1;
	tick(2);
	t_ext;
	t_wait;
	t_int;
	t_pins;
	finish_test;
end
initial begin
	#1000000;
	miscompares = miscompares + 1;
	finish_test;
end
endmodule // testbench
